// [char_lcd_command_decoder.sv]
// Purpose: Instruction decoder of a character display controller.
//    Host side of the 4/8-bit bus.
// Assumes: Asynchronous bus pins; one 200 MHz clock.
// Notes: Display-side read ports expose the character and glyph memories.

// What this block does
// - Clear fills spaces, zeroes pointer.
// - Home zeroes pointer and shift.
// - Accesses step the pointer.
// - Auto-shift on character writes.
// - Display, cursor, blink bits.
// - Blink alternates the cursor.
// - Six-dot width, slower execution.
// - Inversion overrides cursor and blink.
// - Four-line mode overrides line count.
// - Shift moves cursor or display.
// - Cursor wraps at line ends.
// - Per-line scroll enables.
// - Function set loads width, lines.
// - Function set with page bit loads flash, low power.
// - Page bit picks glyph or icon.
// - Top-bit code loads address.
// - Extended top-bit loads scroll.
// - Status read gives busy, pointer.
// - Data write stores, steps pointer.
// - Clear and home run long.
// - Read buffer preload, stale first read.
// - Four-bit mode, high nibble first.
module char_lcd_command_decoder import char_lcd_pkg::*; #(
   parameter int CLEAR_CYCLES = CLEAR_CYC,
   parameter int CTRL_CYCLES = CTRL_CYC,
   parameter int DATA_CYCLES = DATA_CYC,
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic enable_strobe,
   input wire logic reg_select,
   input wire logic read_not_write,
   input wire logic [7:0] db_in,
   output logic [7:0] db_out,
   output logic db_oe_n,
   input wire logic [6:0] char_rd_addr,
   output logic [7:0] char_rd_data,
   input wire logic [5:0] glyph_rd_addr,
   output logic [5:0] glyph_row,
   output disp_cfg_t disp_cfg,
   output logic [2:0] active_lines,
   output logic [23:0] line_scroll,
   output logic [6:0] display_shift,
   output logic [6:0] address_pointer,
   output logic busy_flag,
   output logic cursor_all_dots,
   output logic cursor_inverted,
   output logic cursor_underline
);

   // Refuse unusable timings.
   initial begin
      if (CLEAR_CYCLES < CHAR_DEPTH || CTRL_CYCLES < 1 || DATA_CYCLES < 1 ||
          BLINK_CYCLES < 1) begin
         $error("char_lcd_command_decoder: cycle counts too small");
      end
   end

   logic e_s1_q, e_s2_q, e_s3_q;
   logic rs_s1_q, rs_s2_q, rw_s1_q, rw_s2_q;
   logic [7:0] db_s1_q, db_s2_q;
   logic rs_h_q, rw_h_q;
   logic [7:0] db_h_q;
   logic nibble_q;
   logic [3:0] hi_q;
   disp_cfg_t cfg_q;
   mem_sel_t mem_sel_q;
   logic [6:0] ac_q, shift_q;
   logic [31:0] busy_cnt_q;
   logic clear_act_q;
   logic [6:0] clear_idx_q;
   logic preload_q;
   logic [7:0] read_buf_q;
   logic [31:0] blink_cnt_q;
   logic blink_phase_q;
   logic [7:0] char_mem [CHAR_DEPTH];
   logic [7:0] glyph_mem [GLYPH_DEPTH];
   logic [7:0] icon_mem [ICON_DEPTH];

   logic take, rise, byte_done, busy, re;
   logic wr_instr, wr_data, rd_data;
   logic [7:0] op;
   logic is_clear, is_home, is_entry, is_disp, is_extfn, is_shift;
   logic is_scren, is_func, is_cgaddr, is_segaddr, is_ddaddr, is_sq;
   logic [31:0] exec_cyc;

   // Steps the pointer in the selected memory.
   function automatic logic [6:0] step_any(mem_sel_t s, logic [6:0] a, logic inc,
                                            logic four, logic two);
      logic [6:0] n;
      n = inc ? a + 7'h01 : a - 7'h01;
      case (s)
         MEM_CHAR: step_any = char_step(a, inc, four, two);
         MEM_GLYPH: step_any = {1'b0, n[5:0]};
         MEM_ICON: step_any = {3'b000, n[3:0]};
         default: step_any = a;
      endcase
   endfunction

   // Two-stage synchronisers for the bus pins.
   always_ff @(posedge clock) begin
      if (rst) begin
         e_s1_q <= 1'b0;
         e_s2_q <= 1'b0;
         e_s3_q <= 1'b0;
         rs_s1_q <= 1'b0;
         rs_s2_q <= 1'b0;
         rw_s1_q <= 1'b0;
         rw_s2_q <= 1'b0;
         db_s1_q <= 8'h00;
         db_s2_q <= 8'h00;
      end else begin
         e_s1_q <= enable_strobe;
         e_s2_q <= e_s1_q;
         e_s3_q <= e_s2_q;
         rs_s1_q <= reg_select;
         rs_s2_q <= rs_s1_q;
         rw_s1_q <= read_not_write;
         rw_s2_q <= rw_s1_q;
         db_s1_q <= db_in;
         db_s2_q <= db_s1_q;
      end
   end

   // Bus values held while the strobe is high.
   always_ff @(posedge clock) begin
      if (rst) begin
         rs_h_q <= 1'b0;
         rw_h_q <= 1'b0;
         db_h_q <= 8'h00;
      end else if (e_s2_q) begin
         rs_h_q <= rs_s2_q;
         rw_h_q <= rw_s2_q;
         db_h_q <= db_s2_q;
      end
   end

   // Strobe edges and decode.
   assign take = e_s3_q & ~e_s2_q;
   assign rise = e_s2_q & ~e_s3_q;
   assign byte_done = take & (cfg_q.bus_width_sel | nibble_q);
   assign op = cfg_q.bus_width_sel ? db_h_q : {hi_q, db_h_q[7:4]};
   assign busy = (busy_cnt_q != 32'h0) | clear_act_q;
   assign re = cfg_q.ext_page_sel;
   assign wr_instr = byte_done & ~rw_h_q & ~rs_h_q & ~busy;
   assign wr_data = byte_done & ~rw_h_q & rs_h_q & ~busy;
   assign rd_data = byte_done & rw_h_q & rs_h_q & ~busy;
   assign is_clear = op == 8'h01;
   assign is_home = op[7:1] == 7'h01;
   assign is_entry = op[7:2] == 6'h01;
   assign is_disp = op[7:3] == 5'h01 && !re;
   assign is_extfn = op[7:3] == 5'h01 && re;
   assign is_shift = op[7:4] == 4'h1 && !re;
   assign is_scren = op[7:4] == 4'h1 && re;
   assign is_func = op[7:5] == 3'h1;
   assign is_cgaddr = op[7:6] == 2'h1 && !re;
   assign is_segaddr = op[7:6] == 2'h1 && re;
   assign is_ddaddr = op[7] && !re;
   assign is_sq = op[7] && re;

   // Execution time with width and power stretch.
   always_comb begin
      int base;
      base = CTRL_CYCLES;
      if (rd_data || wr_data) base = DATA_CYCLES;
      else if (is_clear || is_home) base = CLEAR_CYCLES;
      if (cfg_q.font_width_sel) base = base * 6 / 5;
      if (cfg_q.low_power_mode) base = base * ((active_lines == 3'd1) ? 4 : 2);
      exec_cyc = 32'(base);
   end

   // Nibble pairing.
   always_ff @(posedge clock) begin
      if (rst) begin
         nibble_q <= 1'b0;
         hi_q <= 4'h0;
      end else if (take && !cfg_q.bus_width_sel) begin
         nibble_q <= ~nibble_q;
         if (!nibble_q) hi_q <= db_h_q[7:4];
      end else if (cfg_q.bus_width_sel) begin
         nibble_q <= 1'b0;
      end
   end

   // Mode bits.
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_q <= CFG_RESET;
      end else if (wr_instr) begin
         if (is_clear) cfg_q.entry_inc <= 1'b1;
         if (is_entry) begin
            cfg_q.entry_inc <= op[1];
            cfg_q.auto_shift <= op[0];
         end
         if (is_disp) begin
            cfg_q.display_on <= op[2];
            cfg_q.cursor_on <= op[1];
            cfg_q.blink_on <= op[0];
         end
         if (is_extfn) begin
            cfg_q.font_width_sel <= op[2];
            cfg_q.cursor_invert_en <= op[1];
            cfg_q.four_line_mode <= op[0];
         end
         if (is_scren) cfg_q.scroll_line_en <= op[3:0];
         if (is_sq) cfg_q.scroll_amount <= op[5:0];
         if (is_func) begin
            cfg_q.bus_width_sel <= op[4];
            cfg_q.two_line <= op[3];
            cfg_q.ext_page_sel <= op[2];
            if (op[2]) begin
               cfg_q.glyph_flash_en <= op[1];
               cfg_q.low_power_mode <= op[0];
            end
         end
      end
   end

   // Pointer, memory select and shift.
   always_ff @(posedge clock) begin
      if (rst) begin
         ac_q <= AC_RESET;
         mem_sel_q <= MEM_CHAR;
         shift_q <= 7'h00;
      end else if (wr_instr) begin
         if (is_clear || is_home) begin
            ac_q <= AC_RESET;
            mem_sel_q <= MEM_CHAR;
            shift_q <= 7'h00;
         end
         if (is_shift && !op[3]) begin
            ac_q <= char_step(ac_q, op[2], cfg_q.four_line_mode,
                              cfg_q.two_line);
            mem_sel_q <= MEM_CHAR;
         end
         if (is_shift && op[3]) shift_q <= op[2] ? shift_q - 7'h01 : shift_q + 7'h01;
         if (is_cgaddr) begin
            ac_q <= {1'b0, op[5:0]};
            mem_sel_q <= MEM_GLYPH;
         end
         if (is_segaddr) begin
            ac_q <= {3'b000, op[3:0]};
            mem_sel_q <= MEM_ICON;
         end
         if (is_ddaddr) begin
            ac_q <= op[6:0];
            mem_sel_q <= MEM_CHAR;
         end
      end else if (wr_data || rd_data) begin
         ac_q <= step_any(mem_sel_q, ac_q, cfg_q.entry_inc, cfg_q.four_line_mode,
                          cfg_q.two_line);
         if (wr_data && cfg_q.auto_shift && mem_sel_q == MEM_CHAR) begin
            shift_q <= cfg_q.entry_inc ? shift_q + 7'h01 : shift_q - 7'h01;
         end
      end
   end

   // Busy timer.
   always_ff @(posedge clock) begin
      if (rst) begin
         busy_cnt_q <= 32'h0;
      end else if (wr_instr || wr_data || rd_data) begin
         busy_cnt_q <= exec_cyc;
      end else if (busy_cnt_q != 32'h0) begin
         busy_cnt_q <= busy_cnt_q - 32'h1;
      end
   end

   // Clear sweep of character memory.
   always_ff @(posedge clock) begin
      if (rst) begin
         clear_act_q <= 1'b0;
         clear_idx_q <= 7'h00;
      end else if (wr_instr && is_clear) begin
         clear_act_q <= 1'b1;
         clear_idx_q <= 7'h00;
      end else if (clear_act_q) begin
         clear_idx_q <= clear_idx_q + 7'h01;
         if (clear_idx_q == 7'(CHAR_DEPTH - 1)) clear_act_q <= 1'b0;
      end
   end

   // Memory writes.
   always_ff @(posedge clock) begin
      if (clear_act_q) begin
         char_mem[clear_idx_q] <= SPACE_CODE;
      end else if (wr_data) begin
         case (mem_sel_q)
            MEM_CHAR: char_mem[ac_q] <= op;
            MEM_GLYPH: glyph_mem[ac_q[5:0]] <= op;
            MEM_ICON: icon_mem[ac_q[3:0]] <= op;
            default: ;
         endcase
      end
   end

   // Read buffer reload after reads and address sets; data writes skip it.
   always_ff @(posedge clock) begin
      if (rst) begin
         preload_q <= 1'b0;
         read_buf_q <= 8'h00;
      end else begin
         preload_q <= rd_data | (wr_instr & (is_cgaddr | is_segaddr | is_ddaddr |
                      (is_shift & ~op[3])));
         if (preload_q) begin
            case (mem_sel_q)
               MEM_CHAR: read_buf_q <= char_mem[ac_q];
               MEM_GLYPH: read_buf_q <= glyph_mem[ac_q[5:0]];
               MEM_ICON: read_buf_q <= icon_mem[ac_q[3:0]];
               default: read_buf_q <= 8'h00;
            endcase
         end
      end
   end

   // Read data on the rising strobe.
   always_ff @(posedge clock) begin
      logic [7:0] v;
      v = rs_s2_q ? read_buf_q : {busy, ac_q};
      if (rst) begin
         db_out <= 8'h00;
      end else if (rise && rw_s2_q) begin
         if (cfg_q.bus_width_sel) db_out <= v;
         else db_out <= nibble_q ? {v[3:0], 4'h0} : {v[7:4], 4'h0};
      end
   end

   assign db_oe_n = ~(e_s2_q & rw_s2_q);

   // Blink and inversion phase timer.
   always_ff @(posedge clock) begin
      if (rst) begin
         blink_cnt_q <= 32'h0;
         blink_phase_q <= 1'b0;
      end else if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) begin
         blink_cnt_q <= 32'h0;
         blink_phase_q <= ~blink_phase_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 32'h1;
      end
   end

   // Cursor appearance.
   always_ff @(posedge clock) begin
      if (rst) begin
         cursor_all_dots <= 1'b0;
         cursor_inverted <= 1'b0;
         cursor_underline <= 1'b0;
      end else begin
         cursor_all_dots <= cfg_q.display_on & ~cfg_q.cursor_invert_en &
                            cfg_q.blink_on & blink_phase_q;
         cursor_inverted <= cfg_q.display_on & cfg_q.cursor_invert_en &
                            blink_phase_q;
         cursor_underline <= cfg_q.display_on & ~cfg_q.cursor_invert_en &
                             cfg_q.cursor_on;
      end
   end

   // Line count, scroll and display reads.
   always_ff @(posedge clock) begin
      if (rst) begin
         active_lines <= 3'd1;
         line_scroll <= 24'h0;
         char_rd_data <= 8'h00;
         glyph_row <= 6'h00;
      end else begin
         active_lines <= cfg_q.four_line_mode ? 3'd4 :
                         (cfg_q.two_line ? 3'd2 : 3'd1);
         for (int i = 0; i < 4; i++) begin
            line_scroll[i*6 +: 6] <= cfg_q.scroll_line_en[i] ?
                                     cfg_q.scroll_amount : 6'h00;
         end
         char_rd_data <= char_mem[char_rd_addr];
         glyph_row <= cfg_q.font_width_sel ? glyph_mem[glyph_rd_addr][5:0] :
                      {1'b0, glyph_mem[glyph_rd_addr][4:0]};
      end
   end

   assign disp_cfg = cfg_q;
   assign address_pointer = ac_q;
   assign display_shift = shift_q;
   assign busy_flag = busy;

endmodule

// [char_lcd_pkg.sv]
// Purpose: Shared constants and types of the decoder.
// Assumes: 200 MHz clock; 270 kHz oscillator timing.
// Notes: Long counts become module parameters.
package char_lcd_pkg;

   // Clock period, execution and blink times.
   localparam int CLK_PERIOD_NS = 5;
   localparam int T_CLEAR_NS = 1530000;
   localparam int T_CTRL_NS = 39000;
   localparam int T_DATA_NS = 43000;
   localparam int T_BLINK_NS = 370000000;

   // Least times round up to whole cycles.
   localparam int CLEAR_CYC = (T_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CTRL_CYC = (T_CTRL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_CYC = (T_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLINK_CYC = (T_BLINK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Memory sizes, fill code and pointer reset value.
   localparam int CHAR_DEPTH = 128;
   localparam int GLYPH_DEPTH = 64;
   localparam int ICON_DEPTH = 16;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam logic [6:0] AC_RESET = 7'h00;

   // Line boundaries of the character memory address map.
   localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
   localparam logic [6:0] TWO_L1_LAST = 7'h27;
   localparam logic [6:0] TWO_L2_FIRST = 7'h40;
   localparam logic [6:0] TWO_L2_LAST = 7'h67;
   localparam logic [4:0] FOUR_POS_LAST = 5'h13;

   typedef enum logic [1:0] {
      MEM_CHAR = 2'b00,
      MEM_GLYPH = 2'b01,
      MEM_ICON = 2'b10
   } mem_sel_t;

   typedef struct packed {
      logic display_on;
      logic cursor_on;
      logic blink_on;
      logic font_width_sel;
      logic cursor_invert_en;
      logic four_line_mode;
      logic two_line;
      logic bus_width_sel;
      logic ext_page_sel;
      logic glyph_flash_en;
      logic low_power_mode;
      logic entry_inc;
      logic auto_shift;
      logic [5:0] scroll_amount;
      logic [3:0] scroll_line_en;
   } disp_cfg_t;

   localparam disp_cfg_t CFG_RESET = '{bus_width_sel: 1'b1, entry_inc: 1'b1, default: '0};

   // Steps a character address, wrapping at line ends.
   function automatic logic [6:0] char_step(logic [6:0] a, logic inc, logic four,
                                             logic two);
      logic [6:0] n;
      n = inc ? a + 7'h01 : a - 7'h01;
      if (four) begin
         if (inc && a[4:0] >= FOUR_POS_LAST) n = {a[6:5] + 2'b01, 5'h00};
         else if (!inc && a[4:0] == 5'h00) n = {a[6:5] - 2'b01, FOUR_POS_LAST};
      end else if (two) begin
         if (inc && a == TWO_L1_LAST) n = TWO_L2_FIRST;
         else if (inc && a == TWO_L2_LAST) n = AC_RESET;
         else if (!inc && a == AC_RESET) n = TWO_L2_LAST;
         else if (!inc && a == TWO_L2_FIRST) n = TWO_L1_LAST;
      end else begin
         if (inc && a == ONE_LINE_LAST) n = AC_RESET;
         else if (!inc && a == AC_RESET) n = ONE_LINE_LAST;
      end
      return n;
   endfunction

endpackage

// [char_lcd_chk.sv]
// Purpose: Port checks of the decoder.
// Assumes: Two-stage pin synchroniser.
// Notes: Busy slack of one cycle.
module char_lcd_chk import char_lcd_pkg::*; #(
   parameter int CLEAR_CYCLES = CLEAR_CYC,
   parameter int CTRL_CYCLES = CTRL_CYC,
   parameter int DATA_CYCLES = DATA_CYC,
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic enable_strobe,
   input wire logic reg_select,
   input wire logic read_not_write,
   input wire logic [7:0] db_out,
   input wire logic db_oe_n,
   input wire disp_cfg_t disp_cfg,
   input wire logic [2:0] active_lines,
   input wire logic [23:0] line_scroll,
   input wire logic [6:0] address_pointer,
   input wire logic busy_flag,
   input wire logic cursor_all_dots,
   input wire logic cursor_underline
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   int bcnt_q;

   // Counts busy cycles.
   always_ff @(posedge clock) begin
      if (rst || !busy_flag) bcnt_q <= 0;
      else bcnt_q <= bcnt_q + 1;
   end

   // Legal busy lengths, with slack.
   function automatic bit len_ok(int n);
      int b[3];
      bit ok;
      b = '{CLEAR_CYCLES, CTRL_CYCLES, DATA_CYCLES};
      ok = 1'b0;
      foreach (b[i]) for (int m = 1; m <= 4; m++) begin
         ok |= (n >= b[i] * m - 1) && (n <= b[i] * m + 1);
         ok |= (n >= b[i] * m * 6 / 5 - 1) && (n <= b[i] * m * 6 / 5 + 1);
      end
      return ok;
   endfunction

   // Expected scroll word.
   function automatic logic [23:0] scroll_of(disp_cfg_t c);
      for (int i = 0; i < 4; i++) scroll_of[6*i +: 6] = c.scroll_line_en[i] ? c.scroll_amount : 6'h00;
   endfunction

   sequence seq_status_rd;
      $rose(enable_strobe) && !reg_select && read_not_write && disp_cfg.bus_width_sel;
   endsequence
   sequence seq_hold_high;
      enable_strobe [*6];
   endsequence

   a_status_word: assert property (seq_status_rd ##0 seq_hold_high |->
      db_out[6:0] == address_pointer) else $error("status read pointer wrong");
   a_oe_read: assert property (!db_oe_n |->
      ($past(read_not_write, 2) && $past(enable_strobe, 2)) ||
      ($past(read_not_write, 3) && $past(enable_strobe, 3))) else $error("bus driven outside read");
   a_line_count: assert property (1 |=> active_lines == ($past(disp_cfg.four_line_mode) ? 3'h4 :
      $past(disp_cfg.two_line) ? 3'h2 : 3'h1)) else $error("line count wrong");
   a_scroll_gate: assert property (1 |=> line_scroll == scroll_of($past(disp_cfg)))
      else $error("line scroll wrong");
   a_busy_len: assert property ($fell(busy_flag) |-> len_ok(bcnt_q))
      else $error("busy length wrong");
   a_busy_cause: assert property ($rose(busy_flag) |-> !enable_strobe &&
      ($past(enable_strobe, 4) || $past(enable_strobe, 5) || $past(enable_strobe, 6)))
      else $error("busy without transfer");
   a_ptr_cause: assert property ($changed(address_pointer) |-> !enable_strobe &&
      ($past(enable_strobe, 3) || $past(enable_strobe, 4) || $past(enable_strobe, 5) ||
      $past(enable_strobe, 6))) else $error("pointer moved without transfer");
   a_invert_quiet: assert property (disp_cfg.cursor_invert_en &&
      $past(disp_cfg.cursor_invert_en) |-> !cursor_all_dots && !cursor_underline)
      else $error("cursor shown under inversion");
   a_blink_gate: assert property (cursor_all_dots |-> $past(disp_cfg.blink_on))
      else $error("blink without enable");
   a_cursor_gate: assert property (cursor_underline |-> $past(disp_cfg.cursor_on))
      else $error("cursor without enable");
endmodule

bind char_lcd_command_decoder char_lcd_chk #(.CLEAR_CYCLES(CLEAR_CYCLES),
   .CTRL_CYCLES(CTRL_CYCLES), .DATA_CYCLES(DATA_CYCLES), .BLINK_CYCLES(BLINK_CYCLES))
   u_chk (.clock, .rst, .enable_strobe, .reg_select, .read_not_write, .db_out, .db_oe_n,
   .disp_cfg, .active_lines, .line_scroll, .address_pointer, .busy_flag, .cursor_all_dots,
   .cursor_underline);

// [char_lcd_host.sv]
// Purpose: Host on the 4/8-bit bus.
// Assumes: Pins change 1 ns after an edge.
// Notes: Released lines show the inverse.
module char_lcd_host #(
   parameter int HALF_OSC = 370
) (
   input wire logic clock,
   output logic enable_strobe,
   output logic reg_select,
   output logic read_not_write,
   output logic [7:0] db_in,
   input wire logic [7:0] db_out
);
   logic four_bit = 1'b0;

   // Bus idles with the strobe low.
   initial begin
      enable_strobe = 1'b0;
      reg_select = 1'b0;
      read_not_write = 1'b0;
      db_in = 8'h00;
   end

   // Waits n edges plus 1 ns.
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // One byte, high nibble first in four-bit mode.
   task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                       output logic [7:0] q);
      for (int i = 0; i < (four_bit ? 2 : 1); i++) begin
         reg_select = rs;
         read_not_write = rw;
         db_in = four_bit ? {(i == 0 ? d[7:4] : d[3:0]), 4'h0} : d;
         enable_strobe = 1'b1;
         tick(8);
         q = !four_bit ? db_out : i == 0 ? {db_out[7:4], 4'h0} : {q[7:4], db_out[7:4]};
         enable_strobe = 1'b0;
         tick(4);
         db_in = ~db_in;
         tick(4);
      end
   endtask

   // Polls until ready, then waits.
   task automatic ready();
      logic [7:0] s;
      int n;
      n = 0;
      do begin
         xfer(1'b0, 1'b1, 8'h00, s);
         n++;
      end while (s[7] !== 1'b0 && n < 400);
      tick(HALF_OSC);
   endtask

   // Instruction write; tracks bus width.
   task automatic cmd(input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b0, 1'b0, d, q);
      if (d[7:5] == 3'h1) four_bit = !d[4];
      ready();
   endtask

   // Data write and data read.
   task automatic wr(input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b1, 1'b0, d, q);
      ready();
   endtask
   task automatic rd(output logic [7:0] q);
      xfer(1'b1, 1'b1, 8'h00, q);
      ready();
   endtask
endmodule

// [tb_char_lcd_command_decoder.sv]
// Purpose: Bench for the decoder.
// Assumes: Short timings.
// Notes: Busy slack of one cycle.
module tb_char_lcd_command_decoder import char_lcd_pkg::*; ();
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CLR = 200;
   localparam int CTL = 20;
   localparam int DAT = 25;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic enable_strobe, reg_select, read_not_write, db_oe_n, busy_flag;
   logic cursor_all_dots, cursor_inverted, cursor_underline;
   logic [7:0] db_in, db_out, char_rd_data, q;
   logic [6:0] char_rd_addr;
   logic [6:0] display_shift, address_pointer;
   logic [5:0] glyph_rd_addr;
   logic [5:0] glyph_row;
   logic [2:0] active_lines;
   logic [23:0] line_scroll;
   disp_cfg_t disp_cfg;
   int error_cnt = 0;
   int tests_run = 0;
   int bcnt = 0;
   int blen = 0;

   // Bench clock of 5 ns.
   always #2.5 clock = ~clock;

   char_lcd_command_decoder #(.CLEAR_CYCLES(CLR), .CTRL_CYCLES(CTL), .DATA_CYCLES(DAT),
      .BLINK_CYCLES(50)) u_dut (.clock, .rst, .enable_strobe, .reg_select, .read_not_write,
      .db_in, .db_out, .db_oe_n, .char_rd_addr, .char_rd_data, .glyph_rd_addr, .glyph_row,
      .disp_cfg, .active_lines, .line_scroll, .display_shift, .address_pointer, .busy_flag,
      .cursor_all_dots, .cursor_inverted, .cursor_underline);
   char_lcd_host h (.clock, .enable_strobe, .reg_select, .read_not_write, .db_in, .db_out);

   // Busy period length.
   always @(posedge clock) begin
      if (busy_flag === 1'b1) bcnt++;
      else if (bcnt != 0) begin
         blen = bcnt;
         bcnt = 0;
      end
   end

   // Compares values and busy lengths.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic chk_len(input string n, input int e);
      tests_run++;
      if (blen < e - 1 || blen > e + 1) begin
         error_cnt++;
         $display("Error %s expected %0d seen %0d", n, e, blen);
      end
   endtask

   // Prints the counts and the verdict.
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Clear after a decrementing write.
   task automatic t_clear();
      chk("cfg", CFG_RESET, disp_cfg);
      h.cmd(8'h04);
      h.cmd(8'h85);
      h.wr(8'h41);
      chk_len("wr_len", DAT);
      chk("ptr_dec", 7'h04, address_pointer);
      char_rd_addr = 7'h05;
      h.tick(2);
      chk("char", 8'h41, char_rd_data);
      h.cmd(8'h01);
      chk_len("clr_len", CLR);
      chk("clr_ptr", 7'h00, address_pointer);
      chk("clr_inc", 1'b1, disp_cfg.entry_inc);
      chk("space", 8'h20, char_rd_data);
   endtask

   // Cursor and display shifts, then home.
   task automatic t_shift();
      h.cmd(8'h8A);
      h.cmd(8'h18);
      chk_len("ctl_len", CTL);
      chk("dsp_l", 7'h01, display_shift);
      h.cmd(8'h1C);
      h.cmd(8'h1C);
      chk("dsp_r", 7'h7F, display_shift);
      chk("dsp_ptr", 7'h0A, address_pointer);
      h.cmd(8'h14);
      chk("cur_r", 7'h0B, address_pointer);
      h.cmd(8'h10);
      chk("cur_l", 7'h0A, address_pointer);
      h.cmd(8'h02);
      chk_len("home_len", CLR);
      chk("home", 14'h0000, {address_pointer, display_shift});
      chk("keep", 8'h20, char_rd_data);
   endtask

   // Line wrap in two and four line modes.
   task automatic t_wrap();
      h.cmd(8'h38);
      chk("lines2", 3'h2, active_lines);
      h.cmd(8'hA7);
      h.cmd(8'h14);
      chk("wrap2", 7'h40, address_pointer);
      h.cmd(8'h3C);
      h.cmd(8'h09);
      h.cmd(8'h30);
      chk("lines4", 3'h4, active_lines);
      h.cmd(8'h93);
      h.cmd(8'h14);
      chk("wrap4", 7'h20, address_pointer);
      h.cmd(8'h3C);
      h.cmd(8'h08);
      h.cmd(8'h38);
      chk("lines_b", 3'h2, active_lines);
   endtask

   // Extended page codes.
   task automatic t_ext();
      h.cmd(8'h3E);
      chk("page", 2'h3, {disp_cfg.ext_page_sel, disp_cfg.glyph_flash_en});
      h.cmd(8'h15);
      h.cmd(8'hA5);
      chk("scroll", 24'h025025, line_scroll);
      chk("sq_ptr", 7'h20, address_pointer);
      h.cmd(8'h5E);
      chk("icon", 7'h0E, address_pointer);
      h.wr(8'h11);
      h.wr(8'h22);
      chk("icon_wrap", 7'h00, address_pointer);
      h.cmd(8'h3D);
      chk("lp", 1'b1, disp_cfg.low_power_mode);
      h.cmd(8'h3C);
      h.cmd(8'h38);
      chk("page0", 1'b0, disp_cfg.ext_page_sel);
      h.cmd(8'h5E);
      chk("glyph", 7'h1E, address_pointer);
      h.cmd(8'hA5);
      chk("ddr", 7'h25, address_pointer);
   endtask

   // Writes, reads, glyph rows, width timing.
   task automatic t_entry();
      h.cmd(8'h07);
      h.cmd(8'hA0);
      h.wr(8'h61);
      chk("s_inc", 14'h1081, {address_pointer, display_shift});
      h.cmd(8'h05);
      h.wr(8'h62);
      chk("s_dec", 14'h1000, {address_pointer, display_shift});
      h.cmd(8'hA0);
      h.rd(q);
      chk_len("rd_len", DAT);
      chk("rd1", 8'h61, q);
      h.rd(q);
      chk("rd2", 8'h20, q);
      chk("rd_ptr", 14'h0F00, {address_pointer, display_shift});
      h.cmd(8'h42);
      h.wr(8'h3F);
      chk("g_ptr", 14'h0080, {address_pointer, display_shift});
      glyph_rd_addr = 6'h02;
      h.tick(2);
      chk("row5", 6'h1F, glyph_row);
      h.cmd(8'h3C);
      h.cmd(8'h0C);
      chk("row6", 6'h3F, glyph_row);
      h.cmd(8'h06);
      chk_len("fw_len", CTL * 6 / 5);
      h.cmd(8'h08);
      h.cmd(8'h38);
   endtask

   // Blink and inversion duty.
   task automatic t_disp();
      int a;
      int v;
      h.cmd(8'h0F);
      chk("dcb", 3'h7, {disp_cfg.display_on, disp_cfg.cursor_on, disp_cfg.blink_on});
      chk("under", 1'b1, cursor_underline);
      for (int k = 0; k < 2; k++) begin
         a = 0;
         v = 0;
         repeat (200) begin
            h.tick(1);
            a += int'(cursor_all_dots === 1'b1);
            v += int'(cursor_inverted === 1'b1);
         end
         chk("dots", k ? 0 : 100, a);
         chk("inv", k ? 100 : 0, v);
         h.cmd(8'h3C);
         h.cmd(k ? 8'h08 : 8'h0A);
      end
      h.cmd(8'h38);
      h.cmd(8'h0B);
      char_rd_addr = 7'h20;
      h.tick(2);
      chk("off_keep", 9'h061, {disp_cfg.display_on, char_rd_data});
   endtask

   // Four-bit bus transfers.
   task automatic t_nibble();
      h.cmd(8'h28);
      chk("w4", 1'b0, disp_cfg.bus_width_sel);
      h.cmd(8'hC5);
      h.xfer(1'b0, 1'b1, 8'h00, q);
      chk("n_stat", 8'h45, q);
      h.wr(8'hC3);
      char_rd_addr = 7'h45;
      h.tick(2);
      chk("n_data", 8'hC3, char_rd_data);
      h.cmd(8'h38);
      chk("w8", 1'b1, disp_cfg.bus_width_sel);
   endtask

   // Reset, then the scenarios in order.
   initial begin
      char_rd_addr = 7'h00;
      glyph_rd_addr = 6'h00;
      h.tick(4);
      rst = 1'b0;
      h.tick(1);
      t_clear();
      t_shift();
      t_wrap();
      t_ext();
      t_entry();
      t_disp();
      t_nibble();
      conclude();
   end

   // Cuts a hang short.
   initial begin
      #400us;
      error_cnt++;
      conclude();
   end
endmodule
